// ### ssp_port.sv
// serial peripheral port: control, status, data registers and clocking
// assumes a simple cpu bus with one-cycle read/write strobes
`timescale 1ns/100ps
`include "ssp_defines.svh"
// Summary of operation
// - enable takes port c bits 0,1,2 as clock, data out, data in
// - clearing enable resets serial logic and frees port c pins 0 and 2
// - data-out pin is input when disabled, driven output when enabled
// - port c reads give pin levels; port data register unused
// - role set: master drives clock pin; clear: slave, clock is input
// - master: data write starts eight clock pulses
// - master rate is clock/16 with rate bit set, clock/2 clear
// - master clock rests high when idle and after eighth pulse
// - serial output changes on falling clock edge
// - slave shifts on external clock, ignores rate, latches input
// - 3-bit counter counts pulses; overflow sets done flag, halts
// - slave ignores clocks while done flag set
// - order bit set shifts lsb first, clear shifts msb first
// - interrupt raised while done flag and irq enable both set
// - interrupt held as level while enable and flag stay set
// - done flag cleared by status read then data access
// - collision set on data access while shifting without status read
// - collision cleared by status read with done flag set, then data access
// - control, data read/write; status read-only; ctrl bits 3:1 zero
// - done flag set on rising edge of eighth clock
// - collision raises no interrupt, transfer continues unaffected
// - data writes ignored while shifting or flag set without status read
module ssp_port
  import ssp_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // cpu register port
  input  wire logic [1:0] addr_i,
  input  wire logic       rd_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  output logic            irq_o,
  // port c pins 0..2 and general purpose side
  input  wire logic [2:0] pc_in_i,
  input  wire logic [2:0] gp_out_i,
  input  wire logic [2:0] gp_oe_i,
  output logic      [2:0] pc_out_o,
  output logic      [2:0] pc_oe_o
);
  ssp_shift_if sh ();

  ssp_shifter u_shift (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .sh     (sh)
  );

  logic [7:0] ctrl_r, ctrl_nxt;
  logic       done_r, done_nxt;
  logic       coll_r, coll_nxt;
  logic       armed_r, armed_nxt;
  logic       busy_r, busy_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [3:0] div_r, div_nxt;
  logic       sck_r, sck_nxt;
  logic       sdo_r, sdo_nxt;
  logic       sin_r, sin_nxt;
  logic [7:0] rdata_nxt;
  logic       irq_nxt;
  logic [2:0] pout_nxt, poe_nxt;
  ssp_state_e st_r, st_nxt;

  logic en, master, rise, fall, data_acc, stat_rd, wr_ok;

  assign en       = ctrl_r[`SSP_BIT_ENABLE];
  assign master   = ctrl_r[`SSP_BIT_ROLE];
  assign data_acc = (rd_i | wr_i) && addr_i == `SSP_ADDR_DATA;
  assign stat_rd  = rd_i && addr_i == `SSP_ADDR_STAT;
  assign wr_ok    = wr_i && addr_i == `SSP_ADDR_DATA
                    && !busy_r && !(done_r && !armed_r);

  // serial clock edges: own divider in master, external pin in slave
  always_comb begin
    st_nxt  = st_r;
    div_nxt = div_r;
    sck_nxt = sck_r;
    rise    = 1'b0;
    fall    = 1'b0;
    if (master) begin
      unique case (st_r)
        SSP_IDLE: begin
          sck_nxt = 1'b1;
          if (wr_ok) begin
            st_nxt  = SSP_HIGH;
            div_nxt = 4'h0;
          end
        end
        SSP_HIGH, SSP_LOW: begin
          div_nxt = div_r + 4'h1;
          if (div_nxt == (ctrl_r[`SSP_BIT_RATE] ? `SSP_DIV_SLOW
                                                : `SSP_DIV_FAST)) begin
            div_nxt = 4'h0;
            if (st_r == SSP_HIGH) begin
              st_nxt  = SSP_LOW;
              sck_nxt = 1'b0;
              fall    = 1'b1;
            end else begin
              sck_nxt = 1'b1;
              rise    = 1'b1;
              st_nxt  = (cnt_r == 3'h7) ? SSP_IDLE : SSP_HIGH;
            end
          end
        end
      endcase
    end else begin
      st_nxt  = SSP_IDLE;
      sck_nxt = pc_in_i[0];
      rise    = !sck_r && pc_in_i[0] && !done_r;
      fall    = sck_r && !pc_in_i[0] && !done_r;
    end
    if (!en) begin
      st_nxt  = SSP_IDLE;
      sck_nxt = 1'b1;
      rise    = 1'b0;
      fall    = 1'b0;
    end
  end

  // registers, flags, counter
  always_comb begin
    ctrl_nxt  = ctrl_r;
    done_nxt  = done_r;
    coll_nxt  = coll_r;
    armed_nxt = armed_r;
    busy_nxt  = busy_r;
    cnt_nxt   = cnt_r;
    sdo_nxt   = sdo_r;
    sin_nxt   = sin_r;
    if (wr_i && addr_i == `SSP_ADDR_CTRL) begin
      ctrl_nxt = {wdata_i[7:4], 3'h0, wdata_i[0]};
    end
    if (stat_rd && done_r) begin
      armed_nxt = 1'b1;
    end
    if (data_acc) begin
      if (armed_r) begin
        done_nxt  = 1'b0;
        coll_nxt  = 1'b0;
        armed_nxt = 1'b0;
      end
      if (busy_r && !armed_r) begin
        coll_nxt = 1'b1;
      end
    end
    if (rise) begin
      sin_nxt = pc_in_i[2];
      busy_nxt = 1'b1;
      cnt_nxt = cnt_r + 3'h1;
      if (cnt_r == 3'h7) begin
        done_nxt = 1'b1;
        busy_nxt = 1'b0;
      end
    end
    if (fall) begin
      busy_nxt = 1'b1;
      if (cnt_r == 3'h0) begin
        sdo_nxt = sh.out_bit;
      end else begin
        sdo_nxt = sh.lsb_first ? sh.data[1] : sh.data[6];
      end
    end
    if (wr_ok) begin
      sdo_nxt = ctrl_r[`SSP_BIT_ORDER] ? wdata_i[0] : wdata_i[7];
      busy_nxt = master;
    end
    if (!en) begin
      busy_nxt = 1'b0;
      cnt_nxt  = 3'h0;
    end
  end

  // shifter drive: load on accepted write, shift on falling edges after the first and on eighth rising edge
  assign sh.load      = wr_ok;
  assign sh.load_data = wdata_i;
  assign sh.lsb_first = ctrl_r[`SSP_BIT_ORDER];
  assign sh.sample    = rise;
  assign sh.in_bit    = pc_in_i[2];
  assign sh.shift     = fall && cnt_r != 3'h0 || rise && cnt_r == 3'h7;

  // read mux, interrupt and pin outputs
  always_comb begin
    unique case (addr_i)
      `SSP_ADDR_CTRL:  rdata_nxt = ctrl_r;
      `SSP_ADDR_STAT:  rdata_nxt = {done_r, coll_r, 6'h00};
      `SSP_ADDR_DATA:  rdata_nxt = sh.data;
      `SSP_ADDR_PORTC: rdata_nxt = {5'h00, pc_in_i};
    endcase
    irq_nxt  = ctrl_r[`SSP_BIT_IRQEN] && done_nxt;
    pout_nxt = gp_out_i;
    poe_nxt  = gp_oe_i;
    if (en) begin
      pout_nxt = {1'b0, sdo_nxt, sck_nxt};
      poe_nxt  = {1'b0, 1'b1, master};
    end else begin
      poe_nxt[1] = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl_r   <= `SSP_CTRL_RESET;
      done_r   <= 1'b0;
      coll_r   <= 1'b0;
      armed_r  <= 1'b0;
      busy_r   <= 1'b0;
      cnt_r    <= 3'h0;
      div_r    <= 4'h0;
      sck_r    <= 1'b1;
      sdo_r    <= 1'b1;
      sin_r    <= 1'b0;
      st_r     <= SSP_IDLE;
      rdata_o  <= 8'h00;
      irq_o    <= 1'b0;
      pc_out_o <= 3'h0;
      pc_oe_o  <= 3'h0;
    end else begin
      ctrl_r   <= ctrl_nxt;
      done_r   <= done_nxt;
      coll_r   <= coll_nxt;
      armed_r  <= armed_nxt;
      busy_r   <= busy_nxt;
      cnt_r    <= cnt_nxt;
      div_r    <= div_nxt;
      sck_r    <= sck_nxt;
      sdo_r    <= sdo_nxt;
      sin_r    <= sin_nxt;
      st_r     <= st_nxt;
      rdata_o  <= rdata_nxt;
      irq_o    <= irq_nxt;
      pc_out_o <= pout_nxt;
      pc_oe_o  <= poe_nxt;
    end
  end
endmodule : ssp_port

// ### ssp_defines.svh
// serial port constants: register offsets, field positions, reset values
// assumes inclusion by bare name from the port design module
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH
`define SSP_ADDR_CTRL     2'h0
`define SSP_ADDR_STAT     2'h1
`define SSP_ADDR_DATA     2'h2
`define SSP_ADDR_PORTC    2'h3
`define SSP_CTRL_RESET    8'h00
`define SSP_BIT_IRQEN     7
`define SSP_BIT_ENABLE    6
`define SSP_BIT_ORDER     5
`define SSP_BIT_ROLE      4
`define SSP_BIT_RATE      0
`define SSP_DIV_FAST      4'h1
`define SSP_DIV_SLOW      4'h8
`endif

// ### ssp_pkg.sv
// serial port types
// assumes ssp_defines.svh is on the include path
package ssp_pkg;
  typedef enum logic [1:0] {SSP_IDLE, SSP_LOW, SSP_HIGH} ssp_state_e;
endpackage : ssp_pkg

// ### ssp_shift_if.sv
// shifter control and data between the port top and its shift engine
// assumes one clock domain
`timescale 1ns/100ps
interface ssp_shift_if;
  logic       load;
  logic [7:0] load_data;
  logic       lsb_first;
  logic       sample;
  logic       shift;
  logic       in_bit;
  logic [7:0] data;
  logic       out_bit;
  modport ctrl (output load, load_data, lsb_first, sample, shift, in_bit,
                input  data, out_bit);
  modport eng  (input  load, load_data, lsb_first, sample, shift, in_bit,
                output data, out_bit);
endinterface : ssp_shift_if

// ### ssp_shifter.sv
// 8-bit shift register with selectable bit order
// assumes sample and shift are single-cycle strobes; a shift with sample
// takes the fresh input bit directly
`timescale 1ns/100ps
module ssp_shifter
  import ssp_pkg::*;
(
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_i,
  // shifter port
  ssp_shift_if.eng  sh
);
  logic [7:0] data_r;
  logic [7:0] data_nxt;
  logic       in_r;
  logic       in_nxt;

  always_comb begin
    data_nxt = data_r;
    in_nxt   = in_r;
    if (sh.load) begin
      data_nxt = sh.load_data;
    end else begin
      if (sh.sample) begin
        in_nxt = sh.in_bit;
      end
      if (sh.shift) begin
        if (sh.lsb_first) begin
          data_nxt = {in_nxt, data_r[7:1]};
        end else begin
          data_nxt = {data_r[6:0], in_nxt};
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      in_r <= 1'b0;
    end else begin
      in_r <= in_nxt;
    end
    data_r <= data_nxt;
  end

  assign sh.data    = data_r;
  assign sh.out_bit = sh.lsb_first ? data_r[0] : data_r[7];
endmodule : ssp_shifter

// ### ssp_port_chk.sv
// checker bound to ssp_port
// assumes one clock and a sync active-high reset
`timescale 1ns/100ps
module ssp_port_chk (
  // clock, reset
  input wire logic       mclk_i,
  input wire logic       rst_i,
  // cpu side
  input wire logic [1:0] addr_i,
  input wire logic       rd_i,
  input wire logic       wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic       irq_o,
  // pins
  input wire logic [2:0] pc_in_i,
  input wire logic [2:0] gp_out_i,
  input wire logic [2:0] gp_oe_i,
  input wire logic [2:0] pc_out_o,
  input wire logic [2:0] pc_oe_o
);
  logic [7:0] ctl_r;
  logic [7:0] ctl_nxt;
  logic       cw;
  logic       sck;
  assign cw = wr_i && addr_i == 2'h0;
  assign sck = pc_out_o[0];
  always_comb ctl_nxt = cw ? wdata_i : ctl_r;
  always_ff @(posedge mclk_i) ctl_r <= rst_i ? 8'h00 : ctl_nxt;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_fast; !sck ##1 sck; endsequence
  sequence s_slow; !sck [*8] ##1 sck; endsequence
  a_ctrl_zero: assert property (
    rd_i && addr_i == 2'h0 |=> rdata_o[3:1] == 3'h0) else $error("ctrl");
  a_pin_read: assert property (
    rd_i && addr_i == 2'h3 |=> rdata_o[2:0] == $past(pc_in_i))
    else $error("pins");
  a_reset_quiet: assert property (
    $fell(rst_i) |-> !irq_o && pc_oe_o == 3'h0) else $error("reset");
  a_en_pins: assert property (
    cw && wdata_i[6] |-> ##[1:3] pc_oe_o == {2'b01, ctl_r[4]})
    else $error("enable");
  a_dis_free: assert property (
    cw && !wdata_i[6] |-> ##[1:3] pc_oe_o == gp_oe_i) else $error("off");
  a_irq_needs_en: assert property (
    irq_o |-> ctl_r[7]) else $error("irq");
  a_fast_half: assert property (
    ctl_r[6] && ctl_r[4] && !ctl_r[0] && pc_oe_o[0] && $fell(sck)
    |-> s_fast) else $error("fast");
  a_slow_half: assert property (
    ctl_r[6] && ctl_r[4] && ctl_r[0] && pc_oe_o[0] && $fell(sck)
    |-> s_slow) else $error("slow");
endmodule : ssp_port_chk
bind ssp_port ssp_port_chk i_chk (.*);

// ### ssp_peer.sv
// serial device on the far side of the port pins
// assumes the clock wire idles high; tx_r is loaded by the bench
`timescale 1ns/100ps
module ssp_peer (
  // clocks
  input  wire logic mclk_i,
  input  wire logic sck_i,
  // data, bit order and clock out
  input  wire logic din_i,
  input  wire logic lsb_i,
  output logic      sck_o,
  output logic      dout_o
);
  logic [7:0] tx_r = 8'h00;
  logic [7:0] rx_r = 8'h00;
  initial sck_o = 1'b1;
  initial dout_o = 1'b0;
  always @(negedge sck_i) begin
    dout_o <= lsb_i ? tx_r[0] : tx_r[7];
    tx_r <= lsb_i ? tx_r >> 1 : tx_r << 1;
  end
  always @(posedge sck_i)
    rx_r <= lsb_i ? {din_i, rx_r[7:1]} : {rx_r[6:0], din_i};
  task automatic clock_byte(input int half);
    repeat (8) begin
      repeat (half) @(posedge mclk_i);
      sck_o <= 1'b0;
      repeat (half) @(posedge mclk_i);
      sck_o <= 1'b1;
    end
  endtask : clock_byte
endmodule : ssp_peer

// ### ssp_port_tb_top.sv
// self-checking bench for the serial port and its peer
// assumes ssp_port, ssp_peer and the checker are compiled
`timescale 1ns/100ps
module ssp_port_tb_top;
  logic       mclk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       rd_i = 1'b0;
  logic       wr_i = 1'b0;
  logic       lsb = 1'b0;
  logic [1:0] addr_i = 2'h0;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  logic [7:0] q;
  logic       irq_o;
  logic [2:0] pc_in_i;
  logic [2:0] pc_out_o;
  logic [2:0] pc_oe_o;
  logic       p_sck;
  logic       p_dout;
  int         bad_count = 0;
  int         cmp_count = 0;
  always #4 mclk_i = ~mclk_i;
  assign pc_in_i = {p_dout, pc_oe_o[1] ? pc_out_o[1] : 1'b1,
                    pc_oe_o[0] ? pc_out_o[0] : p_sck};
  ssp_port i_dut (.mclk_i, .rst_i, .addr_i, .rd_i, .wr_i, .wdata_i,
    .rdata_o, .irq_o, .pc_in_i, .gp_out_i(3'h5), .gp_oe_i(3'h0),
    .pc_out_o, .pc_oe_o);
  ssp_peer i_peer (.mclk_i, .sck_i(pc_in_i[0]), .din_i(pc_in_i[1]),
    .lsb_i(lsb), .sck_o(p_sck), .dout_o(p_dout));
  task automatic chk(input string n, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic acc(input logic [1:0] a, input logic w, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wr_i <= w;
    rd_i <= !w;
    wdata_i <= d;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    wr_i <= 1'b0;
    #1 q = rdata_o;
  endtask : acc
  task automatic t_master(input logic o, r);
    lsb <= o;
    i_peer.tx_r = 8'hb4;
    acc(2'h0, 1'b1, {2'b01, o, 1'b1, 3'h0, r});
    acc(2'h2, 1'b1, 8'ha5);
    if (r) acc(2'h2, 1'b1, 8'h00);
    q = 8'h00;
    for (int i = 0; i < 200 && !q[7]; i++) acc(2'h1, 1'b0, 8'h00);
    chk("status", {1'b1, r, 6'h0}, q);
    chk("sck rest", 8'h01, {7'h0, pc_in_i[0]});
    acc(2'h2, 1'b0, 8'h00);
    chk("master rx", 8'hb4, q);
    chk("peer rx", 8'ha5, i_peer.rx_r);
    acc(2'h1, 1'b0, 8'h00);
    chk("cleared", 8'h00, q);
    $display("master test done");
  endtask : t_master
  task automatic t_slave();
    lsb <= 1'b0;
    i_peer.tx_r = 8'hc3;
    acc(2'h0, 1'b1, 8'hc0);
    acc(2'h2, 1'b1, 8'h5a);
    i_peer.clock_byte(3);
    repeat (6) @(posedge mclk_i);
    #1 chk("irq", 8'h01, {7'h0, irq_o});
    chk("slave tx", 8'h5a, i_peer.rx_r);
    i_peer.tx_r = 8'h0f;
    i_peer.clock_byte(3);
    #1 chk("irq hold", 8'h01, {7'h0, irq_o});
    acc(2'h1, 1'b0, 8'h00);
    chk("slave status", 8'h80, q);
    acc(2'h2, 1'b0, 8'h00);
    chk("slave rx", 8'hc3, q);
    repeat (2) @(posedge mclk_i);
    #1 chk("irq clear", 8'h00, {7'h0, irq_o});
    acc(2'h0, 1'b1, 8'h00);
    repeat (4) @(posedge mclk_i);
    #1 chk("released", 8'h00, {5'h0, pc_oe_o});
    $display("slave test done");
  endtask : t_slave
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    acc(2'h0, 1'b0, 8'h00);
    chk("ctrl reset", 8'h00, q);
    acc(2'h1, 1'b1, 8'hff);
    acc(2'h1, 1'b0, 8'h00);
    chk("status ro", 8'h00, q);
    acc(2'h0, 1'b1, 8'hbf);
    acc(2'h0, 1'b0, 8'h00);
    chk("ctrl rw", 8'hb1, q);
    acc(2'h3, 1'b0, 8'h00);
    chk("pins", 8'h03, {5'h0, q[2:0]});
    $display("register test done");
    for (int k = 0; k < 4; k++) t_master(k[0], k[1]);
    t_slave();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    bad_count++;
    wrap_up();
  end
endmodule : ssp_port_tb_top
